// file: rtl/front_panel_debug_control.v
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "front_panel_defs.vh"

module front_panel_debug_control (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        key_valid,
  input  wire [4:0]  key_code,
  input  wire        run_key,
  input  wire        halt_key,
  input  wire        restart_key,
  input  wire        debug_req_n,
  input  wire        cpu_instr_done,
  input  wire        cpu_halt_exec,
  output wire        run_mode,
  output wire        mem_req,
  output wire        mem_we,
  output wire [15:0] mem_addr,
  output wire [7:0]  mem_wdata,
  input  wire        mem_ack,
  input  wire [7:0]  mem_rdata,
  output wire [23:0] disp_digits,
  output wire        disp_blank,
  output wire [5:0]  disp_dash_mask,
  output wire [2:0]  disp_suffix,
  output wire        disp_small_zero,
  output wire        disp_error
);

  // --------------------------------------------
  // State
  // --------------------------------------------
  localparam [2:0] M_IDLE   = 3'h0;
  localparam [2:0] M_READ   = 3'h1;
  localparam [2:0] M_WRITE  = 3'h2;
  localparam [2:0] M_VREQ   = 3'h3;
  localparam [2:0] M_VERIFY = 3'h4;

  reg [7:0]  img_ff [0:10];
  reg [1:0]  ctrl_ff;
  reg        run_ff;
  reg        halt_pend_ff;
  reg        show_pc_ff;
  reg [15:0] ref_ff;
  reg [1:0]  chain_ff;
  reg        pend_ff;
  reg [1:0]  op_ff;
  reg [2:0]  ent_reg_ff;
  reg [2:0]  ent_cnt_ff;
  reg [2:0]  ent_need_ff;
  reg [2:0]  ent_base_ff;
  reg [15:0] ent_val_ff;
  reg [2:0]  mst_ff;
  reg        mem_req_ff;
  reg        mem_we_ff;
  reg [15:0] mem_addr_ff;
  reg [7:0]  mem_wdata_ff;
  reg [23:0] digits_ff;
  reg [5:0]  mask_ff;
  reg [2:0]  suffix_ff;
  reg        small_zero_ff;
  reg        error_ff;
  reg        wb_ack_ff;
  reg [31:0] wb_dat_ff;
  integer    i;

  // --------------------------------------------
  // Helpers
  // --------------------------------------------
  function is_wide;
    input [2:0] r;
    begin
      is_wide = ~r[2];
    end
  endfunction

  function [3:0] img_base;
    input [2:0] r;
    begin
      if (is_wide(r)) begin
        img_base = {1'b0, r[1:0], 1'b0};
      end else begin
        img_base = {1'b0, r} + 4'h4;
      end
    end
  endfunction

  function [23:0] put_nib;
    input [23:0] d;
    input [2:0]  pos;
    input [3:0]  v;
    reg   [23:0] t;
    integer      k;
    begin
      t = d;
      for (k = 0; k < 6; k = k + 1) begin
        if (pos == k[2:0]) begin
          t[23 - 4 * k -: 4] = v;
        end
      end
      put_nib = t;
    end
  endfunction

  wire [2:0]  rd_reg    = key_code[2:0];
  wire [4:0]  ld_diff   = key_code - `KEY_LOAD_BASE;
  wire [2:0]  ld_reg    = ld_diff[2:0];
  wire [3:0]  rd_b      = img_base(rd_reg);
  wire [15:0] rd_val    = is_wide(rd_reg) ? {img_ff[rd_b], img_ff[rd_b + 4'h1]} : {8'h00, img_ff[rd_b]};
  wire [15:0] pc_val    = {img_ff[0], img_ff[1]};
  wire [15:0] ref_inc   = ref_ff + 16'h0001;
  wire [15:0] rd_addr   = (chain_ff == `CHAIN_READ) ? ref_inc : ref_ff;
  wire [15:0] wr_addr   = (chain_ff == `CHAIN_WRITE) ? ref_inc : ref_ff;
  wire [15:0] ent_next  = {ent_val_ff[11:0], key_code[3:0]};
  wire [2:0]  ent_pos   = ent_base_ff + ent_cnt_ff;
  wire [2:0]  cnt_next  = ent_cnt_ff + 3'h1;
  wire [3:0]  ent_b     = img_base(ent_reg_ff);
  wire        mem_idle  = (mst_ff == M_IDLE);
  wire        wb_take   = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
  wire        img_hit   = (wb_adr_i[7:6] == 2'b01) && (wb_adr_i[5:2] < `IMG_COUNT) && (wb_adr_i[1:0] == 2'b00);
  wire        step_mode = ctrl_ff[`CTRL_STEP_BIT];
  wire        halt_dbg  = ctrl_ff[`CTRL_HALTDBG_BIT];

  // Step, halt key and debug request end a run only on an instruction boundary, so the saved state is whole
  wire        stop_at_done = step_mode | halt_pend_ff | ~debug_req_n;
  wire        run_exit  = run_ff & (restart_key
                                    | (cpu_halt_exec & halt_dbg)
                                    | (cpu_instr_done & stop_at_done));

  // --------------------------------------------
  // Bus read mux
  // --------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_CTRL:    rd_mux = {30'h0, ctrl_ff};
      `OFS_STATUS:  rd_mux = {25'h0, mst_ff != M_IDLE, error_ff, chain_ff, pend_ff, halt_pend_ff, run_ff};
      `OFS_DISPLAY: rd_mux = {8'h00, digits_ff};
      `OFS_ATTR:    rd_mux = {20'h0, small_zero_ff, error_ff, suffix_ff, mask_ff, run_ff};
      `OFS_REFADDR: rd_mux = {16'h0, ref_ff};
      default: begin
        if (img_hit) begin
          rd_mux = {24'h0, img_ff[wb_adr_i[5:2]]};
        end
      end
    endcase
  end

  // --------------------------------------------
  // Main sequencer
  // --------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      for (i = 0; i < 11; i = i + 1) begin
        img_ff[i] <= `IMG_RESET;
      end
      ctrl_ff       <= `CTRL_RESET;
      run_ff        <= 1'b0;
      halt_pend_ff  <= 1'b0;
      show_pc_ff    <= 1'b1;
      ref_ff        <= 16'h0000;
      chain_ff      <= `CHAIN_IDLE;
      pend_ff       <= 1'b0;
      op_ff         <= `OP_LOAD_REG;
      ent_reg_ff    <= 3'h0;
      ent_cnt_ff    <= 3'h0;
      ent_need_ff   <= 3'h0;
      ent_base_ff   <= 3'h0;
      ent_val_ff    <= 16'h0000;
      mst_ff        <= M_IDLE;
      mem_req_ff    <= 1'b0;
      mem_we_ff     <= 1'b0;
      mem_addr_ff   <= 16'h0000;
      mem_wdata_ff  <= 8'h00;
      digits_ff     <= 24'h000000;
      mask_ff       <= 6'h00;
      suffix_ff     <= 3'h0;
      small_zero_ff <= 1'b0;
      error_ff      <= 1'b0;
      wb_ack_ff     <= 1'b0;
      wb_dat_ff     <= 32'h0000_0000;
    end else begin
      // Registered ack: one wait cycle, unmapped reads give zero
      wb_ack_ff <= wb_take;
      wb_dat_ff <= rd_mux;
      if (wb_take & wb_we_i & wb_sel_i[0]) begin
        if (wb_adr_i == `OFS_CTRL) begin
          ctrl_ff <= wb_dat_i[1:0];
        end else if (img_hit) begin
          img_ff[wb_adr_i[5:2]] <= wb_dat_i[7:0];
        end
      end

      if (run_ff) begin
        // Halt opcode with the ignore setting leaves the run going
        if (halt_key) begin
          halt_pend_ff <= 1'b1;
        end
        if (run_exit) begin
          run_ff       <= 1'b0;
          halt_pend_ff <= 1'b0;
          show_pc_ff   <= 1'b1;
        end
      end else if (restart_key) begin
        // Restart in debug drops any command in progress
        pend_ff    <= 1'b0;
        mst_ff     <= M_IDLE;
        mem_req_ff <= 1'b0;
        show_pc_ff <= 1'b1;
      end else if (show_pc_ff) begin
        show_pc_ff    <= 1'b0;
        digits_ff     <= {pc_val, 8'h00};
        suffix_ff     <= 3'h1;
        mask_ff       <= 6'h00;
        small_zero_ff <= 1'b0;
        error_ff      <= 1'b0;
        ref_ff        <= pc_val;
        chain_ff      <= `CHAIN_IDLE;
      end else if (!mem_idle) begin
        // Keys are ignored while a memory cycle is outstanding
        case (mst_ff)
          M_READ: begin
            if (mem_ack) begin
              mem_req_ff      <= 1'b0;
              digits_ff[7:0]  <= mem_rdata;
              mst_ff          <= M_IDLE;
            end
          end
          M_WRITE: begin
            if (mem_ack) begin
              mem_req_ff <= 1'b0;
              mst_ff     <= M_VREQ;
            end
          end
          M_VREQ: begin
            mem_req_ff <= 1'b1;
            mem_we_ff  <= 1'b0;
            mst_ff     <= M_VERIFY;
          end
          M_VERIFY: begin
            if (mem_ack) begin
              mem_req_ff     <= 1'b0;
              digits_ff[7:0] <= mem_rdata;
              error_ff       <= (mem_rdata != mem_wdata_ff);
              mst_ff         <= M_IDLE;
            end
          end
          default: begin
            mem_req_ff <= 1'b0;
            mst_ff     <= M_IDLE;
          end
        endcase
      end else if (run_key && !pend_ff) begin
        run_ff   <= 1'b1;
        chain_ff <= `CHAIN_IDLE;
      end else if (key_valid && pend_ff) begin
        if (key_code == `KEY_ADDR_ABORT) begin
          pend_ff       <= 1'b0;
          small_zero_ff <= 1'b1;
          digits_ff     <= 24'h000000;
          mask_ff       <= 6'h00;
          suffix_ff     <= 3'h0;
          chain_ff      <= `CHAIN_IDLE;
        end else if (!key_code[4]) begin
          digits_ff  <= put_nib(digits_ff, ent_pos, key_code[3:0]);
          mask_ff    <= mask_ff & ~(6'h01 << ent_pos);
          ent_val_ff <= ent_next;
          ent_cnt_ff <= cnt_next;
          if (cnt_next == ent_need_ff) begin
            pend_ff <= 1'b0;
            case (op_ff)
              `OP_LOAD_REG: begin
                if (is_wide(ent_reg_ff)) begin
                  img_ff[ent_b]        <= ent_next[15:8];
                  img_ff[ent_b + 4'h1] <= ent_next[7:0];
                  ref_ff               <= ent_next;
                end else begin
                  img_ff[ent_b] <= ent_next[7:0];
                end
              end
              `OP_ADDR: begin
                ref_ff      <= ent_next;
                mem_addr_ff <= ent_next;
                mem_we_ff   <= 1'b0;
                mem_req_ff  <= 1'b1;
                mst_ff      <= M_READ;
                chain_ff    <= `CHAIN_READ;
              end
              default: begin
                mem_addr_ff  <= ref_ff;
                mem_wdata_ff <= ent_next[7:0];
                mem_we_ff    <= 1'b1;
                mem_req_ff   <= 1'b1;
                mst_ff       <= M_WRITE;
              end
            endcase
          end
        end
      end else if (key_valid) begin
        small_zero_ff <= 1'b0;
        error_ff      <= 1'b0;
        mask_ff       <= 6'h00;
        ent_cnt_ff    <= 3'h0;
        ent_val_ff    <= 16'h0000;
        if (key_code == `KEY_ADDR_ABORT) begin
          pend_ff     <= 1'b1;
          op_ff       <= `OP_ADDR;
          ent_need_ff <= 3'h4;
          ent_base_ff <= 3'h0;
          mask_ff     <= `MASK_WIDE;
          digits_ff   <= 24'h000000;
          suffix_ff   <= 3'h0;
          chain_ff    <= `CHAIN_IDLE;
        end else if (key_code < `KEY_LOAD_BASE) begin
          suffix_ff <= rd_reg + 3'h1;
          chain_ff  <= `CHAIN_IDLE;
          if (is_wide(rd_reg)) begin
            digits_ff <= {rd_val, 8'h00};
            ref_ff    <= rd_val;
          end else begin
            digits_ff <= {rd_val[7:0], 16'h0000};
          end
        end else if (key_code < `KEY_READ_MEM) begin
          pend_ff     <= 1'b1;
          op_ff       <= `OP_LOAD_REG;
          ent_reg_ff  <= ld_reg;
          ent_need_ff <= is_wide(ld_reg) ? 3'h4 : 3'h2;
          ent_base_ff <= 3'h0;
          mask_ff     <= is_wide(ld_reg) ? `MASK_WIDE : `MASK_NARROW;
          digits_ff   <= 24'h000000;
          suffix_ff   <= ld_reg + 3'h1;
          chain_ff    <= `CHAIN_IDLE;
        end else if (key_code == `KEY_READ_MEM) begin
          ref_ff      <= rd_addr;
          digits_ff   <= {rd_addr, 8'h00};
          suffix_ff   <= 3'h0;
          mem_addr_ff <= rd_addr;
          mem_we_ff   <= 1'b0;
          mem_req_ff  <= 1'b1;
          mst_ff      <= M_READ;
          chain_ff    <= `CHAIN_READ;
        end else begin
          ref_ff      <= wr_addr;
          digits_ff   <= {wr_addr, 8'h00};
          mask_ff     <= `MASK_DATA;
          suffix_ff   <= 3'h0;
          pend_ff     <= 1'b1;
          op_ff       <= `OP_LOAD_MEM;
          ent_need_ff <= 3'h2;
          ent_base_ff <= `DATA_POS;
          chain_ff    <= `CHAIN_WRITE;
        end
      end
    end
  end

  // --------------------------------------------
  // Outputs
  // --------------------------------------------
  assign wb_ack_o        = wb_ack_ff;
  assign wb_dat_o        = wb_dat_ff;
  assign run_mode        = run_ff;
  assign mem_req         = mem_req_ff;
  assign mem_we          = mem_we_ff;
  assign mem_addr        = mem_addr_ff;
  assign mem_wdata       = mem_wdata_ff;
  assign disp_digits     = digits_ff;
  assign disp_blank      = run_ff;
  assign disp_dash_mask  = mask_ff;
  assign disp_suffix     = suffix_ff;
  assign disp_small_zero = small_zero_ff;
  assign disp_error      = error_ff;

endmodule // front_panel_debug_control

// file: rtl/front_panel_defs.vh
`ifndef FRONT_PANEL_DEFS_VH
`define FRONT_PANEL_DEFS_VH

// --------------------------------------------
// Register offsets (byte addresses)
// --------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_DISPLAY     8'h08
`define OFS_ATTR        8'h0C
`define OFS_REFADDR     8'h10
`define OFS_IMG_BASE    8'h40
`define IMG_COUNT       4'hB

// --------------------------------------------
// Control fields and reset values
// --------------------------------------------
`define CTRL_STEP_BIT   0
`define CTRL_HALTDBG_BIT 1
`define CTRL_RESET      2'h0
`define IMG_RESET       8'h00

// --------------------------------------------
// Keypad codes in command meaning
// --------------------------------------------
`define KEY_READ_BASE   5'h00
`define KEY_LOAD_BASE   5'h07
`define KEY_READ_MEM    5'h0E
`define KEY_LOAD_MEM    5'h0F
`define KEY_ADDR_ABORT  5'h10

// --------------------------------------------
// Chain flag, entry kinds, dash masks
// --------------------------------------------
`define CHAIN_IDLE      2'h0
`define CHAIN_READ      2'h1
`define CHAIN_WRITE     2'h2
`define OP_LOAD_REG     2'h0
`define OP_ADDR         2'h1
`define OP_LOAD_MEM     2'h2
`define MASK_WIDE       6'h0F
`define MASK_NARROW     6'h03
`define MASK_DATA       6'h30
`define DATA_POS        3'h4

`endif

// file: sim/front_panel_debug_control_asserts.sv
`timescale 1ns/1ps
`include "front_panel_defs.vh"

module front_panel_debug_control_asserts (
  input wire        core_clk,
  input wire        rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        key_valid,
  input wire [4:0]  key_code,
  input wire        run_key,
  input wire        restart_key,
  input wire        debug_req_n,
  input wire        cpu_instr_done,
  input wire        cpu_halt_exec,
  input wire        run_mode,
  input wire        mem_req,
  input wire        mem_ack,
  input wire [15:0] mem_addr,
  input wire        disp_blank,
  input wire [5:0]  disp_dash_mask,
  input wire [2:0]  disp_suffix,
  input wire        disp_small_zero,
  input wire        disp_error
);
  // ----------------------------------------
  // Shadow of the control switches
  // ----------------------------------------
  reg  [1:0] ctrl_ff;
  reg        busy_d_ff;
  // Keys are left unchecked in the cycle after a memory answer, a run or a restart
  wire       key_ok = key_valid && !run_mode && !mem_req && !busy_d_ff && !restart_key && !run_key;

  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_ff   <= 2'h0;
      busy_d_ff <= 1'b1;
    end else begin
      busy_d_ff <= mem_ack || run_mode || restart_key;
      if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0])
        ctrl_ff <= wb_dat_i[1:0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack late or long");
  property p_blank; disp_blank == run_mode; endproperty
  a_blank: assert property (p_blank) else $error("readout not blank in run");
  property p_step; run_mode && cpu_instr_done && ctrl_ff[0] |=> !run_mode; endproperty
  a_step: assert property (p_step) else $error("step did not stop");
  property p_hold; run_mode && !cpu_instr_done && !restart_key && !(cpu_halt_exec && ctrl_ff[1]) |=> run_mode; endproperty
  a_hold: assert property (p_hold) else $error("run ended mid instruction");
  property p_ign; run_mode && cpu_halt_exec && !ctrl_ff[1] && !cpu_instr_done && !restart_key |=> run_mode; endproperty
  a_ign: assert property (p_ign) else $error("halt opcode not ignored");
  property p_halt; run_mode && cpu_halt_exec && ctrl_ff[1] |=> !run_mode; endproperty
  a_halt: assert property (p_halt) else $error("halt opcode did not stop");
  property p_dbg; run_mode && cpu_instr_done && !debug_req_n |=> !run_mode; endproperty
  a_dbg: assert property (p_dbg) else $error("debug line ignored");
  property p_restart; run_mode && restart_key |=> !run_mode; endproperty
  a_restart: assert property (p_restart) else $error("restart did not stop");
  property p_entry; $fell(run_mode) |=> disp_suffix == 3'h1 && disp_dash_mask == 6'h00; endproperty
  a_entry: assert property (p_entry) else $error("no counter shown on entry");
  property p_abort; key_ok && key_code == `KEY_ADDR_ABORT && disp_dash_mask != 6'h00
    |=> disp_small_zero && disp_dash_mask == 6'h00; endproperty
  a_abort: assert property (p_abort) else $error("cancel not honoured");
  property p_wprompt; key_ok && key_code == `KEY_LOAD_MEM && disp_dash_mask == 6'h00
    |=> disp_dash_mask == `MASK_DATA; endproperty
  a_wprompt: assert property (p_wprompt) else $error("write prompt wrong");
  property p_fill; key_ok && key_code < 5'h10 && disp_dash_mask == `MASK_WIDE |=> disp_dash_mask == 6'h0E; endproperty
  a_fill: assert property (p_fill) else $error("digit not leftmost");
  property p_mreq; mem_req && !mem_ack && !restart_key |=> mem_req && $stable(mem_addr); endproperty
  a_mreq: assert property (p_mreq) else $error("memory request dropped");
  property p_err; $rose(disp_error) |-> $past(mem_ack); endproperty
  a_err: assert property (p_err) else $error("error without readback");
endmodule // front_panel_debug_control_asserts

bind front_panel_debug_control front_panel_debug_control_asserts u_chk (
  .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .key_valid(key_valid), .key_code(key_code), .run_key(run_key), .restart_key(restart_key),
  .debug_req_n(debug_req_n),
  .cpu_instr_done(cpu_instr_done), .cpu_halt_exec(cpu_halt_exec), .run_mode(run_mode),
  .mem_req(mem_req), .mem_ack(mem_ack), .mem_addr(mem_addr), .disp_blank(disp_blank),
  .disp_dash_mask(disp_dash_mask), .disp_suffix(disp_suffix), .disp_small_zero(disp_small_zero),
  .disp_error(disp_error));

// file: sim/debug_mem_model.sv
`timescale 1ns/1ps

module debug_mem_model #(
  parameter ROM_BASE = 16'hF000
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [3:0]  wait_cycles,
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire [15:0] mem_addr,
  input  wire [7:0]  mem_wdata,
  output wire        mem_ack,
  output wire [7:0]  mem_rdata
);
  reg [7:0] mem [0:65535];
  reg [3:0] cnt_ff;
  reg       ack_ff;
  reg [7:0] rd_ff;
  integer   i;

  initial begin
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = i[7:0];
    rd_ff = 8'h00;
  end

  always @(posedge core_clk) begin
    if (rst || ack_ff) begin
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
    end else if (mem_req && cnt_ff >= wait_cycles) begin
      ack_ff <= 1'b1;
      rd_ff  <= mem[mem_addr];
      // Top area is read only, so a write there fails verify
      if (mem_we && mem_addr < ROM_BASE)
        mem[mem_addr] <= mem_wdata;
    end else if (mem_req) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  assign mem_ack   = ack_ff;
  // Stale data turned over so a late sample cannot pass
  assign mem_rdata = ack_ff ? rd_ff : ~rd_ff;
endmodule // debug_mem_model

// file: sim/tb_front_panel_debug_control.sv
`timescale 1ns/1ps

module tb_front_panel_debug_control;
  reg         core_clk, rst, cs, we, kv, dbg_n;
  reg  [7:0]  adr;
  reg  [31:0] wdat, q;
  reg  [4:0]  kc, evs;
  reg  [3:0]  mem_wait;
  reg  [31:0] row [0:6];
  wire [31:0] rdat;
  wire        ack, run_mode, mem_req, mem_we, mem_ack, blank, szero, err;
  wire [15:0] mem_addr;
  wire [7:0]  mem_wdata, mem_rdata;
  wire [23:0] dig;
  wire [5:0]  dash;
  wire [2:0]  sfx;
  integer     fails, check_count, cyc_cnt, i;

  front_panel_debug_control dut (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .key_valid(kv), .key_code(kc),
    .run_key(evs[0]), .halt_key(evs[1]), .restart_key(evs[2]), .debug_req_n(dbg_n),
    .cpu_instr_done(evs[3]), .cpu_halt_exec(evs[4]), .run_mode(run_mode), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .disp_digits(dig), .disp_blank(blank), .disp_dash_mask(dash),
    .disp_suffix(sfx), .disp_small_zero(szero), .disp_error(err));

  debug_mem_model u_mem (
    .core_clk(core_clk), .rst(rst), .wait_cycles(mem_wait), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task summarize;
    begin
      if (fails == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task chk(input [31:0] s, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
      end
    end
  endtask

  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      cs   <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      @(posedge core_clk);
      while (ack !== 1'b1) @(posedge core_clk);
      q = rdat;
      cs <= 1'b0;
    end
  endtask

  // Waits for four quiet cycles, since verify makes two memory cycles
  task key(input [4:0] c);
    integer n;
    begin
      @(posedge core_clk);
      kv <= 1'b1;
      kc <= c;
      @(posedge core_clk);
      kv <= 1'b0;
      n = 0;
      while (n < 4) begin
        @(posedge core_clk);
        n = mem_req ? 0 : n + 1;
      end
    end
  endtask

  task hex(input [15:0] v, input integer n);
    integer j;
    begin
      for (j = n - 1; j >= 0; j = j - 1)
        key({1'b0, v[4*j+:4]});
    end
  endtask

  task ev(input [4:0] v);
    begin
      @(posedge core_clk);
      evs <= v;
      @(posedge core_clk);
      evs <= 5'h00;
      repeat (2) @(posedge core_clk);
    end
  endtask

  // ----------------------------------------
  // Clock, timeout, sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      fails = fails + 1;
      summarize;
    end
  end

  initial begin
    {rst, cs, we, kv, dbg_n, adr, wdat, kc, evs, mem_wait} = 0;
    rst = 1'b1;
    dbg_n = 1'b1;
    fails = 0;
    check_count = 0;
    cyc_cnt = 0;
    row[0] = 32'h0001_1234;
    row[1] = 32'h0102_5678;
    row[2] = 32'h0203_9ABC;
    row[3] = 32'h0304_DEF0;
    row[4] = 32'h0405_0011;
    row[5] = 32'h0506_0022;
    row[6] = 32'h0607_0033;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(sfx, 3'h1);
    wb(0, 8'h00, 0);
    chk(q, 0);
    wb(0, 8'hFC, 0);
    chk(q, 0);
    for (i = 0; i < 7; i = i + 1) begin
      if (i < 4) begin
        wb(1, 8'h40 + 8 * i, row[i][15:8]);
        wb(1, 8'h44 + 8 * i, row[i][7:0]);
      end else
        wb(1, 8'h50 + 4 * i, row[i][7:0]);
    end
    for (i = 0; i < 7; i = i + 1) begin
      key(row[i][28:24]);
      chk(sfx, row[i][18:16]);
      if (i < 4)
        chk(dig[23:8], row[i][15:0]);
      else
        chk(dig[23:16], row[i][7:0]);
    end
    key(5'h07);
    chk({sfx, dash}, {3'h1, 6'h0F});
    key(5'h0A);
    chk(dash, 6'h0E);
    hex(16'h0BCD, 3);
    wb(0, 8'h40, 0);
    chk(q, 32'hAB);
    wb(0, 8'h44, 0);
    chk(q, 32'hCD);
    key(5'h07);
    key(5'h01);
    key(5'h10);
    chk({szero, dash}, 7'h40);
    wb(0, 8'h40, 0);
    chk(q, 32'hAB);
    key(5'h0B);
    chk({sfx, dash}, {3'h5, 6'h03});
    hex(16'h005C, 2);
    wb(0, 8'h60, 0);
    chk(q, 32'h5C);
    mem_wait <= 4'h3;
    key(5'h10);
    chk(dash, 6'h0F);
    hex(16'h0123, 4);
    chk(dig, 24'h012323);
    key(5'h0E);
    chk(dig, 24'h012424);
    key(5'h0E);
    chk(dig, 24'h012525);
    key(5'h00);
    key(5'h0E);
    chk(dig, 24'hABCDCD);
    key(5'h0F);
    chk({dig[23:8], 2'h0, dash}, {16'hABCD, 8'h30});
    hex(16'h005A, 2);
    chk({err, dig[7:0]}, 9'h05A);
    chk(u_mem.mem[16'hABCD], 8'h5A);
    key(5'h0F);
    chk(dig[23:8], 16'hABCE);
    hex(16'h0000, 2);
    key(5'h0E);
    chk(dig, 24'hABCE00);
    wb(0, 8'h10, 0);
    chk(q, 32'h0000ABCE);
    key(5'h10);
    hex(16'hF000, 4);
    key(5'h0F);
    hex(16'h0077, 2);
    chk(err, 1'b1);
    wb(1, 8'h00, 1);
    ev(5'h01);
    chk({run_mode, blank}, 2'h3);
    ev(5'h08);
    chk({run_mode, sfx, dig[23:8]}, {4'h1, 16'hABCD});
    wb(1, 8'h00, 0);
    ev(5'h01);
    ev(5'h08);
    ev(5'h10);
    chk(run_mode, 1'b1);
    wb(1, 8'h00, 2);
    ev(5'h10);
    chk(run_mode, 1'b0);
    ev(5'h01);
    ev(5'h02);
    chk(run_mode, 1'b1);
    ev(5'h08);
    chk(run_mode, 1'b0);
    ev(5'h01);
    dbg_n <= 1'b0;
    ev(5'h08);
    chk(run_mode, 1'b0);
    dbg_n <= 1'b1;
    ev(5'h01);
    ev(5'h04);
    chk(run_mode, 1'b0);
    key(5'h10);
    ev(5'h04);
    chk({sfx, dash}, {3'h1, 6'h00});
    ev(5'h01);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({run_mode, sfx, dig}, {4'h1, 24'h000000});
    summarize;
  end
endmodule // tb_front_panel_debug_control
